/* inc/sgc_pkg.sv */
// constants shared by the serial gpio shift controller
package sgc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_IN_DATA   = 8'h00;
    localparam logic [7:0] OFF_IRQ_POL   = 8'h10;
    localparam logic [7:0] OFF_PORT_IRQ  = 8'h20;
    localparam logic [7:0] OFF_PORT_CFG  = 8'h24;
    localparam logic [7:0] OFF_PORT_LAST = 8'hA0;
    localparam logic [7:0] OFF_PORT_EN   = 8'hA4;
    localparam logic [7:0] OFF_SETUP     = 8'hA8;
    localparam logic [7:0] OFF_CLK_DIV   = 8'hAC;
    localparam logic [7:0] OFF_IRQ_FLAG  = 8'hB0;
    // shifter_general_setup field positions
    localparam int F_RATE1   = 20;
    localparam int F_RATE0   = 18;
    localparam int F_BLK_RST = 17;
    localparam int F_BIT_IRQ = 13;
    localparam int F_GAP_DIS = 12;
    localparam int F_GAP     = 7;
    localparam int F_SINGLE  = 6;
    localparam int F_AUTO    = 5;
    localparam int F_LD_POL  = 4;
    localparam int F_WIDTH   = 2;
    localparam int F_REV_OUT = 1;
    localparam int F_REV_IN  = 0;
    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [21:0] RST_SETUP = 22'h00_0000;
    localparam logic [11:0] RST_CFG   = 12'h000;
    localparam logic [11:0] RST_DIV   = 12'h000;
    // source select codes
    localparam logic [2:0] SRC_LOW  = 3'h0;
    localparam logic [2:0] SRC_HIGH = 3'h1;
    localparam logic [2:0] SRC_BLK0 = 3'h2;
    localparam logic [2:0] SRC_BLK1 = 3'h3;
    localparam logic [1:0] RATE1_BURST = 2'h3;
    // timing
    localparam int CLK_FREQ_KHZ   = 25000;
    localparam int GAP_STEP_US    = 1050;
    localparam int BLINK_HALF_US  = 25000;
    localparam int GAP_STEP_CYC   = GAP_STEP_US * CLK_FREQ_KHZ / 1000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_US * CLK_FREQ_KHZ / 1000;
    // shift engine states
    typedef enum logic [1:0] {SGC_IDLE, SGC_SHIFT, SGC_LOAD, SGC_GAP} sgc_state_t;
endpackage

/* src/sgc_top.sv */
// serial gpio shift controller: registers, blink generators, burst shifter
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - per-port interrupt enable vector
// - four 3-bit source selects per port
// - codes 0..3: low, high, blink0, blink1
// - codes 4..7: activity blink, 6/7 inverted
// - port enable vector, all off at reset
// - blink1 rates 20/10/5 Hz or burst toggle
// - blink0 rates 20/10/5/2.5 Hz
// - blink reset bit holds blink counters
// - per-bit-position interrupt enable for all ports
// - gap disable removes gap between bursts
// - gap length (code+1) times 1.05 ms
// - single shot: one burst, then self-clear
// - auto repeat: bursts until cleared
// - load strobe polarity select
// - port width one to four bits
// - output order high-first, reverse low-first
// - input order low-first, reverse high-first
// - shift clock = clock / divider, 0/1 stop
// - input words: word n bit m = port m bit n
// - input polarity, bit0 also loss-of-signal polarity
// - sticky flags at interrupting level, disabled read 0
module sgc_top
    import sgc_pkg::*;
#(
    parameter int GAP_STEP   = GAP_STEP_CYC,
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // link activity per port, same clock
    input  wire logic [31:0] link_act_i,
    // shift chain pins
    output logic             sclk_o,
    output logic             sdo_o,
    output logic             load_strobe_o,
    input  wire logic        sdi_i,
    // status
    output logic             irq_o,
    output logic      [31:0] los_o
);

    // registers
    logic [31:0] in_data [4];
    logic [31:0] irq_pol [4];
    logic [31:0] irq_flag [4];
    logic [11:0] port_cfg [32];
    logic [31:0] port_irq_enable_bits;
    logic [31:0] port_shift_enable_bits;
    logic [21:0] setup;
    logic [11:0] clk_div;

    // engine state
    sgc_state_t  state;
    logic [11:0] div_cnt;
    logic [7:0]  bits_left;
    logic [7:0]  out_pos;
    logic [7:0]  in_pos;
    logic [23:0] gap_cnt;
    logic [19:0] blink_pre;
    logic [3:0]  blink_cnt;
    logic        burst_tgl;
    logic        sdi_meta;
    logic        sdi_s;

    // participation mask: bit p*4+b set when port p shifts bit b
    function automatic logic [127:0] part_mask(input logic [31:0] en, input logic [1:0] w);
        logic [127:0] m;
        m = '0;
        for (int i = 0; i < 128; i++) begin
            m[i] = en[i / 4] && (2'(i % 4) <= w);
        end
        return m;
    endfunction

    // next participating index from start (inclusive), upward or downward
    function automatic logic [7:0] next_idx(input logic [127:0] m, input logic [7:0] start,
                                            input logic down);
        logic [7:0] r;
        r = start;
        if (down) begin
            for (int i = 0; i < 128; i++) begin
                if (m[i] && 8'(i) <= start) r = 8'(i);
            end
        end else begin
            for (int i = 127; i >= 0; i--) begin
                if (m[i] && 8'(i) >= start) r = 8'(i);
            end
        end
        return r;
    endfunction

    // count of set bits
    function automatic logic [7:0] pop128(input logic [127:0] m);
        logic [7:0] c;
        c = '0;
        for (int i = 0; i < 128; i++) begin
            c = c + 8'(m[i]);
        end
        return c;
    endfunction

    // setup fields
    wire [1:0] rate1    = setup[F_RATE1 +: 2];
    wire [1:0] rate0    = setup[F_RATE0 +: 2];
    wire       blk_rst  = setup[F_BLK_RST];
    wire [3:0] bit_irq  = setup[F_BIT_IRQ +: 4];
    wire       gap_dis  = setup[F_GAP_DIS];
    wire [4:0] gap_code = setup[F_GAP +: 5];
    wire       single   = setup[F_SINGLE];
    wire       auto_rep = setup[F_AUTO];
    wire       ld_pol   = setup[F_LD_POL];
    wire [1:0] width    = setup[F_WIDTH +: 2];
    wire       rev_out  = setup[F_REV_OUT];
    wire       rev_in   = setup[F_REV_IN];

    // shift clock phases; divider below two stops the clock
    wire       div_run = clk_div > 12'd1;
    wire       fall_en = div_run && div_cnt == 12'd0;
    wire       rise_en = div_run && div_cnt == (clk_div >> 1);

    // blink generators
    wire gen0 = blink_cnt[rate0];
    wire gen1 = (rate1 == RATE1_BURST) ? burst_tgl : blink_cnt[rate1];

    // burst geometry
    wire [127:0] mask      = part_mask(port_shift_enable_bits, width);
    wire [7:0]   nbits     = pop128(mask);
    wire [7:0]   out_first = next_idx(mask, rev_out ? 8'd0 : 8'd127, !rev_out);
    wire [7:0]   in_first  = next_idx(mask, rev_in ? 8'd127 : 8'd0, rev_in);
    wire [7:0]   out_step  = rev_out ? out_pos + 8'd1 : out_pos - 8'd1;
    wire [7:0]   in_step   = rev_in ? in_pos - 8'd1 : in_pos + 8'd1;
    wire [7:0]   out_next  = next_idx(mask, out_step, !rev_out);
    wire [7:0]   in_next   = next_idx(mask, in_step, rev_in);

    // output bit source select
    function automatic logic src_bit(input logic [2:0] code, input logic g0, input logic g1,
                                     input logic act);
        logic b;
        case (code)
            SRC_LOW:  b = 1'b0;
            SRC_HIGH: b = 1'b1;
            SRC_BLK0: b = g0;
            SRC_BLK1: b = g1;
            default:  b = (act ? (code[0] ? g1 : g0) : 1'b1) ^ code[1];
        endcase
        return b;
    endfunction

    // value driven for a given stream index
    function automatic logic out_val(input logic [7:0] idx, input logic [11:0] cfg,
                                     input logic g0, input logic g1, input logic act);
        return src_bit(cfg[3 * idx[1:0] +: 3], g0, g1, act);
    endfunction

    wire out_bit_first = out_val(out_first, port_cfg[out_first[6:2]], gen0, gen1,
                                 link_act_i[out_first[6:2]]);
    wire out_bit_next  = out_val(out_next, port_cfg[out_next[6:2]], gen0, gen1,
                                 link_act_i[out_next[6:2]]);

    // register write decode
    wire [7:0] cfg_off   = addr_i - OFF_PORT_CFG;
    wire       word_ok   = addr_i[1:0] == 2'b00;
    wire       wr_pol    = wr_i && word_ok && addr_i[7:4] == OFF_IRQ_POL[7:4];
    wire       wr_flag   = wr_i && word_ok && addr_i[7:4] == OFF_IRQ_FLAG[7:4];
    wire       wr_pirq   = wr_i && addr_i == OFF_PORT_IRQ;
    wire       wr_cfg    = wr_i && word_ok && addr_i >= OFF_PORT_CFG && addr_i <= OFF_PORT_LAST;
    wire       wr_pen    = wr_i && addr_i == OFF_PORT_EN;
    wire       wr_setup  = wr_i && addr_i == OFF_SETUP;
    wire       wr_div    = wr_i && addr_i == OFF_CLK_DIV;

    // engine events
    wire can_start  = div_run && fall_en && (single || auto_rep);
    wire sample_now = state == SGC_SHIFT && rise_en;
    wire burst_done = state == SGC_LOAD && fall_en && load_strobe_o == ld_pol;
    wire irq_level  = sdi_s ^ irq_pol[in_pos[1:0]][in_pos[6:2]];

    // read mux
    wire [31:0] rd_pol  = irq_pol[addr_i[3:2]];
    wire [31:0] rd_flag = irq_flag[addr_i[3:2]] & port_shift_enable_bits;
    wire [31:0] rd_mux =
        (word_ok && addr_i[7:4] == OFF_IN_DATA[7:4])  ? in_data[addr_i[3:2]] :
        (word_ok && addr_i[7:4] == OFF_IRQ_POL[7:4])  ? rd_pol :
        (addr_i == OFF_PORT_IRQ)                      ? port_irq_enable_bits :
        (wr_cfg | (word_ok && addr_i >= OFF_PORT_CFG && addr_i <= OFF_PORT_LAST))
                                                      ? {20'h0_0000, port_cfg[cfg_off[6:2]]} :
        (addr_i == OFF_PORT_EN)                       ? port_shift_enable_bits :
        (addr_i == OFF_SETUP)                         ? {10'h000, setup} :
        (addr_i == OFF_CLK_DIV)                       ? {20'h0_0000, clk_div} :
        (word_ok && addr_i[7:4] == OFF_IRQ_FLAG[7:4]) ? rd_flag : RST_WORD;

    // interrupt gating across all three enables
    logic [31:0] irq_any;
    always_comb begin
        irq_any = '0;
        for (int b = 0; b < 4; b++) begin
            irq_any = irq_any | (irq_flag[b] & port_shift_enable_bits
                      & port_irq_enable_bits & {32{bit_irq[b]}});
        end
    end

    // two-flop synchroniser for the serial input pin
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sdi_meta <= 1'b0;
            sdi_s    <= 1'b0;
        end else begin
            sdi_meta <= sdi_i;
            sdi_s    <= sdi_meta;
        end
    end

    // software registers; a software write of the single-shot bit beats the self clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_irq_enable_bits   <= RST_WORD;
            port_shift_enable_bits <= RST_WORD;
            setup                  <= RST_SETUP;
            clk_div                <= RST_DIV;
            for (int i = 0; i < 4; i++) irq_pol[i] <= RST_WORD;
            for (int i = 0; i < 32; i++) port_cfg[i] <= RST_CFG;
        end else begin
            if (wr_pirq) port_irq_enable_bits <= wdata_i;
            if (wr_pen) port_shift_enable_bits <= wdata_i;
            if (wr_div) clk_div <= wdata_i[11:0];
            if (wr_pol) irq_pol[addr_i[3:2]] <= wdata_i;
            if (wr_cfg) port_cfg[cfg_off[6:2]] <= wdata_i[11:0];
            if (wr_setup) setup <= wdata_i[21:0];
            else if (burst_done) setup[F_SINGLE] <= 1'b0;
        end
    end

    // input words and sticky flags; a new hit wins over a write-one clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 4; i++) begin
                in_data[i]  <= RST_WORD;
                irq_flag[i] <= RST_WORD;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_flag && addr_i[3:2] == 2'(i)) irq_flag[i] <= irq_flag[i] & ~wdata_i;
            end
            if (sample_now) begin
                in_data[in_pos[1:0]][in_pos[6:2]] <= sdi_s;
                if (irq_level) irq_flag[in_pos[1:0]][in_pos[6:2]] <= 1'b1;
            end
        end
    end

    // blink prescaler; halves of 25 ms feed a binary counter
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blink_pre <= '0;
            blink_cnt <= '0;
        end else if (blk_rst) begin
            blink_pre <= '0;
            blink_cnt <= '0;
        end else if (blink_pre == 20'(BLINK_HALF - 1)) begin
            blink_pre <= '0;
            blink_cnt <= blink_cnt + 4'd1;
        end else begin
            blink_pre <= blink_pre + 20'd1;
        end
    end

    // shift clock divider
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= '0;
        end else if (!div_run || div_cnt >= clk_div - 12'd1) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 12'd1;
        end
    end

    // burst engine: shift, load strobe, gap
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state         <= SGC_IDLE;
            sclk_o        <= 1'b0;
            sdo_o         <= 1'b0;
            load_strobe_o <= 1'b1;
            bits_left     <= '0;
            out_pos       <= '0;
            in_pos        <= '0;
            gap_cnt       <= '0;
            burst_tgl     <= 1'b0;
        end else begin
            case (state)
                SGC_IDLE: begin
                    load_strobe_o <= !ld_pol;
                    if (can_start) begin
                        bits_left <= nbits;
                        out_pos   <= out_first;
                        in_pos    <= in_first;
                        sdo_o     <= out_bit_first;
                        state     <= (nbits == 8'd0) ? SGC_LOAD : SGC_SHIFT;
                    end
                end
                SGC_SHIFT: begin
                    if (!div_run) begin
                        sclk_o <= 1'b0;
                        state  <= SGC_IDLE;
                    end else if (rise_en) begin
                        sclk_o <= 1'b1;
                        in_pos <= in_next;
                    end else if (fall_en) begin
                        sclk_o    <= 1'b0;
                        bits_left <= bits_left - 8'd1;
                        if (bits_left == 8'd1) begin
                            state <= SGC_LOAD;
                        end else begin
                            out_pos <= out_next;
                            sdo_o   <= out_bit_next;
                        end
                    end
                end
                SGC_LOAD: begin
                    // strobe stands for one whole shift clock period
                    if (!div_run) begin
                        load_strobe_o <= !ld_pol;
                        state         <= SGC_IDLE;
                    end else if (burst_done) begin
                        load_strobe_o <= !ld_pol;
                        burst_tgl     <= !burst_tgl;
                        gap_cnt       <= '0;
                        state         <= (auto_rep && !gap_dis) ? SGC_GAP : SGC_IDLE;
                    end else if (fall_en) begin
                        load_strobe_o <= ld_pol;
                    end
                end
                SGC_GAP: begin
                    // gap of (code+1) steps of about 1.05 ms
                    if (gap_cnt >= 24'(({19'h0_0000, gap_code} + 24'd1) * 24'(GAP_STEP))) begin
                        state <= SGC_IDLE;
                    end else begin
                        gap_cnt <= gap_cnt + 24'd1;
                    end
                end
                default: state <= SGC_IDLE;
            endcase
        end
    end

    // registered status and read data
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= RST_WORD;
            irq_o   <= 1'b0;
            los_o   <= RST_WORD;
        end else begin
            rdata_o <= rd_i ? rd_mux : RST_WORD;
            irq_o   <= |irq_any;
            los_o   <= (in_data[0] ^ irq_pol[0]) & port_shift_enable_bits;
        end
    end

endmodule
`default_nettype wire

/* tb/sgc_chain_model.sv */
// external shift chain model: latches outputs, feeds inputs
`timescale 1ns/1ns
`default_nettype none
module sgc_chain_model (
    // chain pins
    input  wire logic         clk_sys_i,
    input  wire logic         sclk_i,
    input  wire logic         sdo_i,
    input  wire logic         load_strobe_i,
    output logic              sdi_o,
    // settings and observation
    input  wire logic         pol_i,
    input  wire logic [127:0] in_bits_i,
    output logic      [127:0] out_lat_o,
    output logic      [7:0]   n_lat_o
);
    logic         sclk_q = 1'b0;
    logic         act_q  = 1'b0;
    logic [127:0] work   = '0;
    logic [7:0]   n_work = 8'h00;
    logic [6:0]   idx    = 7'h00;
    wire  logic   act = (load_strobe_i === pol_i);
    assign sdi_o = in_bits_i[idx];
    // chain output always driven, so sdi never floats between frames
    always @(posedge clk_sys_i) begin
        sclk_q <= sclk_i;
        act_q  <= act;
        if (act && !act_q) begin
            out_lat_o <= work;
            n_lat_o   <= n_work;
            n_work    <= 8'h00;
            idx       <= 7'h00;
        end else begin
            if (sclk_i && !sclk_q) begin
                work   <= {work[126:0], sdo_i};
                n_work <= n_work + 8'h01;
            end
            if (!sclk_i && sclk_q) idx <= idx + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* tb/sgc_top_asserts.sv */
// port-level assertion checker for the serial gpio shift controller
`timescale 1ns/1ns
`default_nettype none
module sgc_top_asserts
    import sgc_pkg::*;
#(
    parameter int GAP_STEP   = 20,
    parameter int BLINK_HALF = 50
) (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // chain pins and status
    input wire logic [31:0] link_act_i,
    input wire logic        sclk_o,
    input wire logic        sdo_o,
    input wire logic        load_strobe_o,
    input wire logic        sdi_i,
    input wire logic        irq_o,
    input wire logic [31:0] los_o
);
    logic [11:0] div_q;
    logic [31:0] en_q;
    logic [31:0] pirq_q;
    logic [3:0]  birq_q;
    logic        pol_q;
    logic [11:0] hi_cnt;
    logic [11:0] act_cnt;
    wire  logic  load_act = (load_strobe_o == pol_q);
    // shadows of the written fields the properties need
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q  <= 12'h000;
            en_q   <= 32'h0000_0000;
            pirq_q <= 32'h0000_0000;
            {birq_q, pol_q} <= 5'h00;
        end else if (wr_i) begin
            if (addr_i == OFF_CLK_DIV) div_q <= wdata_i[11:0];
            if (addr_i == OFF_PORT_EN) en_q <= wdata_i;
            if (addr_i == OFF_PORT_IRQ) pirq_q <= wdata_i;
            if (addr_i == OFF_SETUP) {birq_q, pol_q} <= {wdata_i[16:13], wdata_i[4]};
        end
    end
    // run lengths of the sclk high phase and of the active load strobe
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_cnt  <= 12'h000;
            act_cnt <= 12'h000;
        end else begin
            hi_cnt  <= sclk_o ? hi_cnt + 12'h001 : 12'h000;
            act_cnt <= load_act ? act_cnt + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data not zero");
    a_en_readback: assert property ((wr_i && addr_i == OFF_PORT_EN) ##1
        (rd_i && addr_i == OFF_PORT_EN) |=> rdata_o == $past(wdata_i, 2))
        else $error("port enable readback");
    a_cfg_readback: assert property ((wr_i && addr_i == OFF_PORT_LAST) ##1
        (rd_i && addr_i == OFF_PORT_LAST) |=> rdata_o == {20'h0_0000, $past(wdata_i[11:0], 2)})
        else $error("select readback");
    a_unmapped_zero: assert property (rd_i && addr_i >= 8'hC0 |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read");
    a_sclk_stopped: assert property ((div_q < 12'h002) [*3] |-> !sclk_o)
        else $error("shift clock runs");
    a_sclk_high_len: assert property ($fell(sclk_o) && $stable(div_q) |->
        hi_cnt == {1'b0, div_q[11:1]})
        else $error("shift clock high length");
    a_sdo_hold: assert property (sclk_o |-> $stable(sdo_o))
        else $error("serial out moved");
    a_load_width: assert property ($fell(load_act) && act_cnt > 12'h002 && $stable(div_q) |->
        act_cnt == div_q)
        else $error("load strobe length");
    a_irq_gated: assert property (irq_o |-> ($past(pirq_q & en_q) != 32'h0000_0000) &&
        ($past(birq_q) != 4'h0))
        else $error("interrupt not enabled");
    a_los_masked: assert property ((los_o & ~$past(en_q)) == 32'h0000_0000)
        else $error("loss of signal on a disabled port");
    c_load: cover property ($fell(load_act) && act_cnt > 12'h002);
    c_irq: cover property ($rose(irq_o));
    c_read: cover property (rd_i ##1 rdata_o != 32'h0000_0000);
endmodule
bind sgc_top sgc_top_asserts #(.GAP_STEP(GAP_STEP), .BLINK_HALF(BLINK_HALF)) u_chk (.*);
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the serial gpio shift controller
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sgc_pkg::*;
    localparam int DIV = 8;
    localparam int GAP = 20;
    logic         clk_sys_i  = 1'b0;
    logic         reset_n_i  = 1'b0;
    logic [7:0]   addr_i     = 8'h00;
    logic [31:0]  wdata_i    = 32'h0000_0000;
    logic         wr_i       = 1'b0;
    logic         rd_i       = 1'b0;
    logic [31:0]  link_act_i = 32'h0000_0000;
    logic         pol        = 1'b0;
    logic [127:0] in_bits    = 128'h000D;
    logic [31:0]  rdata_o;
    logic [31:0]  los_o;
    logic         sclk_o;
    logic         sdo_o;
    logic         load_strobe_o;
    logic         sdi_i;
    logic         irq_o;
    logic [127:0] out_lat;
    logic [7:0]   n_lat;
    int           cyc        = 0;
    int           bad_count  = 0;
    int           n_checks   = 0;
    sgc_top #(.GAP_STEP(GAP), .BLINK_HALF(50)) u_dut (.*);
    sgc_chain_model u_chain (
        .clk_sys_i(clk_sys_i), .sclk_i(sclk_o), .sdo_i(sdo_o), .load_strobe_i(load_strobe_o),
        .sdi_o(sdi_i), .pol_i(pol), .in_bits_i(in_bits), .out_lat_o(out_lat), .n_lat_o(n_lat));
    // 25 MHz clock and a free cycle count for interval checks
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bus cycles; wr ends with an idle edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(posedge clk_sys_i);
        check(rdata_o, e);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_chk(a, e);
    endtask
    // waits for the next load strobe start, bounded
    task automatic wait_load(output int t, output logic b);
        int n = 0;
        while (load_strobe_o === pol && n < 4000) begin
            @(posedge clk_sys_i);
            n++;
        end
        while (load_strobe_o !== pol && n < 4000) begin
            @(posedge clk_sys_i);
            n++;
        end
        t = cyc;
        @(posedge clk_sys_i);
        b = out_lat[0];
        if (n >= 4000) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic no_load(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            check(load_strobe_o === pol, 1'b0);
        end
    endtask
    task automatic t_reset();
        check(load_strobe_o, 1'b1);
        rd_chk(OFF_PORT_IRQ, 32'h0000_0000);
        rd_chk(OFF_PORT_EN, 32'h0000_0000);
        rd_chk(OFF_PORT_CFG, 32'h0000_0000);
        rd_chk(OFF_SETUP, 32'h0000_0000);
        rd_chk(OFF_CLK_DIV, 32'h0000_0000);
        rd_chk(8'hC0, 32'h0000_0000);
    endtask
    task automatic t_regs();
        wr_rd(OFF_PORT_EN, 32'h8000_0001, 32'h8000_0001);
        wr_rd(OFF_PORT_LAST, 32'hFFFF_FFFF, 32'h0000_0FFF);
        wr_rd(OFF_IN_DATA, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(OFF_PORT_IRQ, 32'h5A5A_5A5A);
        rd_chk(OFF_PORT_IRQ, 32'h5A5A_5A5A);
        wr(OFF_PORT_IRQ, 32'h0000_0000);
    endtask
    // two ports of two bits, forced levels, one single-shot burst
    task automatic t_burst(input logic rev);
        int   t;
        logic b;
        wr(OFF_PORT_EN, 32'h0000_0003);
        wr(OFF_PORT_CFG, 32'h0000_0009);
        wr(OFF_PORT_CFG + 8'h04, 32'h0000_0008);
        pol <= rev;
        wr(OFF_SETUP, 32'h0000_0044 | {27'h0, rev, 2'h0, rev, rev});
        wait_load(t, b);
        check(n_lat, 8'h04);
        check(out_lat[3:0], rev ? 4'hD : 4'hB);
        repeat (2 * DIV) @(posedge clk_sys_i);
        rd_chk(OFF_SETUP, 32'h0000_0004 | {27'h0, rev, 2'h0, rev, rev});
        rd_chk(OFF_IN_DATA, rev ? 32'h0000_0001 : 32'h0000_0003);
        rd_chk(OFF_IN_DATA + 8'h04, rev ? 32'h0000_0003 : 32'h0000_0002);
        no_load(100);
    endtask
    task automatic t_irq();
        rd_chk(OFF_IRQ_FLAG, 32'h0000_0003);
        rd_chk(OFF_IRQ_FLAG + 8'h04, 32'h0000_0002);
        check(los_o, 32'h0000_0003);
        wr(OFF_SETUP, 32'h0000_4000);
        wr(OFF_PORT_IRQ, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        check(irq_o, 1'b0);
        wr(OFF_PORT_IRQ, 32'h0000_0002);
        repeat (3) @(posedge clk_sys_i);
        check(irq_o, 1'b1);
        wr(OFF_SETUP, 32'h0000_0000);
        repeat (3) @(posedge clk_sys_i);
        check(irq_o, 1'b0);
        wr(OFF_SETUP, 32'h0000_4000);
        wr(OFF_IRQ_FLAG + 8'h04, 32'h0000_0002);
        repeat (3) @(posedge clk_sys_i);
        check(irq_o, 1'b0);
        wr(OFF_IRQ_POL, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        check(los_o, 32'h0000_0002);
        wr(OFF_PORT_EN, 32'h0000_0001);
        rd_chk(OFF_IRQ_FLAG, 32'h0000_0001);
        wr(OFF_IRQ_POL, 32'h0000_0000);
        wr(OFF_PORT_IRQ, 32'h0000_0000);
    endtask
    // activity codes with no link activity: steady, 6 and 7 inverted
    task automatic t_codes();
        int   t;
        logic b;
        pol <= 1'b0;
        wr(OFF_PORT_EN, 32'h0000_0001);
        wr(OFF_PORT_CFG, 32'h0000_0FAC);
        wr(OFF_SETUP, 32'h0000_004C);
        wait_load(t, b);
        check(n_lat, 8'h04);
        check(out_lat[3:0], 4'h3);
    endtask
    task automatic t_auto();
        int   t0, t1;
        logic b0, b1;
        wr(OFF_PORT_CFG, 32'h0000_0003);
        wr(OFF_SETUP, 32'h0030_00A0);
        wait_load(t0, b0);
        wait_load(t1, b1);
        check(b0 ^ b1, 1'b1);
        check((t1 - t0 >= 3 * DIV + 2 * GAP) && (t1 - t0 <= 4 * DIV + 2 * GAP + 1), 1'b1);
        wr(OFF_SETUP, 32'h0030_10A0);
        wait_load(t0, b0);
        wait_load(t1, b1);
        check(t1 - t0, 4 * DIV);
        wr(OFF_SETUP, 32'h0000_0000);
        repeat (4 * DIV) @(posedge clk_sys_i);
        no_load(200);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_regs();
        wr(OFF_CLK_DIV, 32'h0000_0008);
        t_burst(1'b0);
        t_irq();
        t_burst(1'b1);
        t_codes();
        t_auto();
        complete_run();
    end
endmodule
`default_nettype wire
